// *** design/bfx_branch_cond.sv ***
/*
 * Branch condition evaluation for the flag branches.
 * Assumes flags are the current status flags register contents.
 */
module bfx_branch_cond import bfx_pkg::*; (
	bfx_exec_if.cond bus
);
	always_comb begin
		case (bus.op)
			OP_BRANCH_IF_CARRY_CLEAR,
			OP_BRANCH_UNSIGNED_GE: bus.taken = ~bus.flags[FLAG_C];
			OP_BRANCH_UNSIGNED_LOWER: bus.taken = bus.flags[FLAG_C];
			OP_BRANCH_IF_NEGATIVE: bus.taken = bus.flags[FLAG_N];
			OP_BRANCH_IF_NONNEGATIVE: bus.taken = ~bus.flags[FLAG_N];
			OP_BRANCH_SIGNED_GE:
				bus.taken = ~(bus.flags[FLAG_N] ^ bus.flags[FLAG_V]);
			OP_BRANCH_SIGNED_LESS:
				bus.taken = bus.flags[FLAG_N] ^ bus.flags[FLAG_V];
			OP_BRANCH_HALF_CARRY_SET: bus.taken = bus.flags[FLAG_H];
			OP_BRANCH_HALF_CARRY_CLEAR: bus.taken = ~bus.flags[FLAG_H];
			OP_BRANCH_TRANSFER_FLAG_SET: bus.taken = bus.flags[FLAG_T];
			OP_BRANCH_TRANSFER_FLAG_CLEAR:
				bus.taken = ~bus.flags[FLAG_T];
			OP_BRANCH_IF_IRQ_ENABLED: bus.taken = bus.flags[FLAG_I];
			OP_BRANCH_IF_IRQ_DISABLED: bus.taken = ~bus.flags[FLAG_I];
			OP_BRANCH_STATUS_BIT_SET:
				bus.taken = bus.flags[bus.bit_sel];
			OP_BRANCH_STATUS_BIT_CLEAR:
				bus.taken = ~bus.flags[bus.bit_sel];
			default: bus.taken = 1'b0;
		endcase
	end
endmodule // bfx_branch_cond

// *** design/bfx_exec.sv ***
/*
 * Execution unit for flag branches, I/O bit set/clear, shifts, rotates,
 * transfer-flag bit moves and status flag set/clear; owns the status
 * flags register.
 * Assumes the decoder holds op_* stable while op_valid is high and that
 * the I/O space answers io_rd with io_rdata in the same cycle.
 */
// Chosen here: the plain strobed port and the placing of the registers.
// What this block does
// - A taken branch loads pc+offset+1 in 2 cycles; untaken takes 1 cycle.
// - Carry-clear and unsigned-ge branch on carry 0, unsigned-lower on 1.
// - Negative branch on N 1, nonnegative on N 0, signed-ge on N xor V 0.
// - Signed-less branches only when N xor V is 1.
// - Half-carry branches test H set or H clear.
// - Transfer-flag branches test T set or T clear.
// - Interrupt-state branches test I set or I clear.
// - I/O bit set/clear force one I/O bit in 2 cycles, flags untouched.
// - Logical shifts fill with 0, arithmetic right keeps bit 7; ZCNV set.
// - Rotates move carry in at one end and out at the other; ZCNV set.
// - Bit store copies a register bit to T; bit load copies T into one.
// - Global irq enable and disable set or clear I in one cycle.
// - Flag set and clear ops change only the addressed flag in 1 cycle.
// - Generic status-bit branches test the selected flag set or clear.
module bfx_exec import bfx_pkg::*; #(
	parameter int PC_W = 16,
	parameter int OFF_W = 7,
	parameter int IO_AW = 5
) (
	input logic mclk,
	input logic rst_b,
	input logic op_valid,
	input bfx_op_e op_code,
	input logic [7:0] op_value,
	input logic [2:0] op_bit,
	input logic [IO_AW-1:0] op_io_addr,
	input logic [OFF_W-1:0] op_offset,
	input logic [PC_W-1:0] op_pc,
	output logic op_ready,
	output logic op_done,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic pc_load,
	output logic [PC_W-1:0] pc_target,
	output logic io_rd,
	output logic io_wr,
	output logic [IO_AW-1:0] io_addr,
	output logic [7:0] io_wdata,
	input logic [7:0] io_rdata,
	input logic [1:0] sw_addr,
	input logic [7:0] sw_wdata,
	input logic sw_wr,
	input logic sw_rd,
	output logic [7:0] sw_rdata,
	output logic [7:0] status_flags
);
	bfx_exec_if ex ();

	bfx_state_e state_r;
	bfx_state_e state_nxt;
	logic accept;
	logic is_branch;
	logic is_io;
	logic [PC_W-1:0] off_ext;
	logic [PC_W-1:0] target_w;
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] result_r;
	logic [7:0] bit_ins;
	logic [7:0] io_mod;
	logic [2:0] io_bit_r;
	logic io_set_r;
	logic done_r;
	logic reg_wr_r;
	logic [7:0] reg_wdata_r;
	logic pc_load_r;
	logic [PC_W-1:0] pc_target_r;
	logic io_wr_r;
	logic [IO_AW-1:0] io_addr_r;
	logic [7:0] io_wdata_r;
	logic [7:0] sw_rdata_r;

	assign ex.op = op_code;
	assign ex.flags = status_r;
	assign ex.bit_sel = op_bit;
	assign ex.value = op_value;

	bfx_branch_cond u_cond (
		.bus(ex.cond)
	);

	bfx_shifter u_shift (
		.bus(ex.shift)
	);

	assign op_ready = (state_r == BFX_IDLE);
	assign accept = op_valid && op_ready;
	assign is_branch = op_code inside {[OP_BRANCH_IF_CARRY_CLEAR :
		OP_BRANCH_STATUS_BIT_CLEAR]};
	assign is_io = (op_code == OP_SET_IO_BIT) || (op_code == OP_CLEAR_IO_BIT);

	// sign extension lets the branch reach backward as well
	assign off_ext = PC_W'($signed(op_offset));
	assign target_w = op_pc + off_ext + PC_W'(1);

	always_comb begin
		bit_ins = op_value;
		bit_ins[op_bit] = status_r[FLAG_T];
		io_mod = io_rdata;
		io_mod[io_bit_r] = io_set_r;
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			BFX_IDLE: begin
				if (accept && is_branch && ex.taken) begin
					state_nxt = BFX_BR2;
				end else if (accept && is_io) begin
					state_nxt = BFX_IO2;
				end
			end
			BFX_BR2: state_nxt = BFX_IDLE;
			BFX_IO2: state_nxt = BFX_IDLE;
			default: state_nxt = BFX_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= BFX_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// an executing op beats a software write on the bits it touches
	always_comb begin
		status_nxt = status_r;
		if (sw_wr && sw_addr == REG_STATUS_ADDR) begin
			status_nxt = sw_wdata;
		end
		if (accept) begin
			case (op_code)
				OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
				OP_SHIFT_RIGHT_ARITH, OP_ROTATE_LEFT_THRU_CARRY,
				OP_ROTATE_RIGHT_THRU_CARRY: begin
					status_nxt[FLAG_C] = ex.shift_c;
					status_nxt[FLAG_Z] = (ex.shift_res == 8'h00);
					status_nxt[FLAG_N] = ex.shift_res[7];
					status_nxt[FLAG_V] = ex.shift_res[7] ^ ex.shift_c;
				end
				OP_STORE_REG_BIT_TO_TRANSFER:
					status_nxt[FLAG_T] = op_value[op_bit];
				OP_GLOBAL_IRQ_ENABLE: status_nxt[FLAG_I] = 1'b1;
				OP_GLOBAL_IRQ_DISABLE: status_nxt[FLAG_I] = 1'b0;
				OP_FLAG_SET: status_nxt[op_bit] = 1'b1;
				OP_FLAG_CLEAR: status_nxt[op_bit] = 1'b0;
				default: status_nxt = status_nxt;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			status_r <= STATUS_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	// register file write-back for shifts and bit load
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_wr_r <= 1'b0;
			reg_wdata_r <= RESULT_RST;
			result_r <= RESULT_RST;
		end else begin
			reg_wr_r <= accept &&
				(ex.is_shift || op_code == OP_LOAD_REG_BIT_FROM_TRANSFER);
			if (accept && ex.is_shift) begin
				reg_wdata_r <= ex.shift_res;
				result_r <= ex.shift_res;
			end else if (accept && op_code == OP_LOAD_REG_BIT_FROM_TRANSFER) begin
				reg_wdata_r <= bit_ins;
				result_r <= bit_ins;
			end
		end
	end

	// program counter redirect one cycle after the taken branch settles
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pc_load_r <= 1'b0;
			pc_target_r <= '0;
		end else begin
			pc_load_r <= (state_r == BFX_BR2);
			if (accept && is_branch) begin
				pc_target_r <= target_w;
			end
		end
	end

	// read-modify-write of one I/O bit over two cycles
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			io_bit_r <= 3'h0;
			io_set_r <= 1'b0;
			io_addr_r <= '0;
			io_wr_r <= 1'b0;
			io_wdata_r <= 8'h00;
		end else begin
			if (accept && is_io) begin
				io_bit_r <= op_bit;
				io_set_r <= (op_code == OP_SET_IO_BIT);
				io_addr_r <= op_io_addr;
			end
			io_wr_r <= (state_r == BFX_IO2);
			if (state_r == BFX_IO2) begin
				io_wdata_r <= io_mod;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (accept && state_nxt == BFX_IDLE) ||
				(state_r == BFX_BR2) || (state_r == BFX_IO2);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sw_rdata_r <= 8'h00;
		end else if (sw_rd) begin
			case (sw_addr)
				REG_STATUS_ADDR: sw_rdata_r <= status_r;
				REG_RESULT_ADDR: sw_rdata_r <= result_r;
				REG_STATE_ADDR: sw_rdata_r <= {5'h00, state_r};
				default: sw_rdata_r <= 8'h00;
			endcase
		end else begin
			sw_rdata_r <= 8'h00;
		end
	end

	assign op_done = done_r;
	assign reg_wr = reg_wr_r;
	assign reg_wdata = reg_wdata_r;
	assign pc_load = pc_load_r;
	assign pc_target = pc_target_r;
	assign io_rd = (state_r == BFX_IO2);
	assign io_wr = io_wr_r;
	assign io_addr = io_addr_r;
	assign io_wdata = io_wdata_r;
	assign sw_rdata = sw_rdata_r;
	assign status_flags = status_r;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	sequence s_taken;
		accept && is_branch && ex.taken;
	endsequence

	sequence s_io_issue;
		accept && is_io;
	endsequence

	property p_br_taken;
		s_taken |=> !op_ready ##1 (pc_load && op_done &&
			pc_target == $past(target_w, 2));
	endproperty
	a_br_taken: assert property (p_br_taken)
		else $error("taken branch target or timing wrong");

	property p_br_untaken;
		accept && is_branch && !ex.taken |=> op_done && !pc_load && op_ready;
	endproperty
	a_br_untaken: assert property (p_br_untaken)
		else $error("untaken branch not single cycle");
	// judged by the state machine, not by the condition helper itself
	property p_carry_cond;
		accept && (op_code == OP_BRANCH_UNSIGNED_LOWER) |=>
			op_ready == !$past(status_r[FLAG_C]);
	endproperty
	a_carry_cond: assert property (p_carry_cond)
		else $error("unsigned lower condition wrong");
	property p_sge_cond;
		accept && (op_code == OP_BRANCH_SIGNED_GE) |=>
			op_ready == $past(status_r[FLAG_N] ^ status_r[FLAG_V]);
	endproperty
	a_sge_cond: assert property (p_sge_cond)
		else $error("signed ge condition wrong");
	property p_slt_cond;
		accept && (op_code == OP_BRANCH_SIGNED_LESS) |=>
			op_ready == !$past(status_r[FLAG_N] ^ status_r[FLAG_V]);
	endproperty
	a_slt_cond: assert property (p_slt_cond)
		else $error("signed less condition wrong");
	property p_io_bit;
		s_io_issue |=> io_rd ##1 (io_wr && op_done &&
			io_wdata[io_bit_r] == io_set_r && io_addr == $past(op_io_addr, 2));
	endproperty
	a_io_bit: assert property (p_io_bit)
		else $error("io bit write wrong");
	property p_shl;
		accept && op_code == OP_SHIFT_LEFT_LOGICAL |=> reg_wr &&
			reg_wdata == {$past(op_value[6:0]), 1'b0} &&
			status_flags[FLAG_C] == $past(op_value[7]);
	endproperty
	a_shl: assert property (p_shl)
		else $error("left shift result wrong");
	property p_rol;
		accept && op_code == OP_ROTATE_LEFT_THRU_CARRY |=>
			reg_wdata[0] == $past(status_r[FLAG_C]) &&
			status_flags[FLAG_C] == $past(op_value[7]);
	endproperty
	a_rol: assert property (p_rol)
		else $error("rotate left carry path wrong");
	property p_bit_store;
		accept && op_code == OP_STORE_REG_BIT_TO_TRANSFER |=>
			status_flags[FLAG_T] == $past(op_value[op_bit]);
	endproperty
	a_bit_store: assert property (p_bit_store)
		else $error("bit store wrong");
	property p_irq_en;
		accept && op_code == OP_GLOBAL_IRQ_ENABLE |=>
			status_flags[FLAG_I] && op_done;
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("irq enable not set");
	property p_flag_set;
		accept && op_code == OP_FLAG_SET && !sw_wr |=>
			status_flags == ($past(status_r) | (8'h01 << $past(op_bit)));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag set touched other flags");
endmodule // bfx_exec

// *** design/bfx_exec_if.sv ***
/*
 * Carrier between the control module and its condition and shift helpers.
 * Assumes all three sit in one clock domain; the bundle is combinational.
 */
interface bfx_exec_if;
	import bfx_pkg::*;

	bfx_op_e op;
	logic [7:0] flags;
	logic [2:0] bit_sel;
	logic [7:0] value;
	logic taken;
	logic [7:0] shift_res;
	logic shift_c;
	logic is_shift;

	modport ctrl(output op, flags, bit_sel, value,
		input taken, shift_res, shift_c, is_shift);
	modport cond(input op, flags, bit_sel, output taken);
	modport shift(input op, flags, value, output shift_res, shift_c, is_shift);
endinterface

// *** design/bfx_pkg.sv ***
/*
 * Shared constants, opcodes and state codes of the branch, bit and flag
 * execution unit.
 * Assumes the core decoder hands over one decoded operation at a time.
 */
package bfx_pkg;

	// positions inside the status flags register
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;

	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] RESULT_RST = 8'h00;

	// software port map
	localparam logic [1:0] REG_STATUS_ADDR = 2'h0;
	localparam logic [1:0] REG_RESULT_ADDR = 2'h1;
	localparam logic [1:0] REG_STATE_ADDR = 2'h2;

	// cycle counts of the documented timing
	localparam int BR_TAKEN_CYCLES = 2;
	localparam int IO_BIT_CYCLES = 2;
	localparam int SINGLE_CYCLES = 1;

	typedef enum logic [4:0] {
		OP_BRANCH_IF_CARRY_CLEAR = 5'h00,
		OP_BRANCH_UNSIGNED_GE = 5'h01,
		OP_BRANCH_UNSIGNED_LOWER = 5'h02,
		OP_BRANCH_IF_NEGATIVE = 5'h03,
		OP_BRANCH_IF_NONNEGATIVE = 5'h04,
		OP_BRANCH_SIGNED_GE = 5'h05,
		OP_BRANCH_SIGNED_LESS = 5'h06,
		OP_BRANCH_HALF_CARRY_SET = 5'h07,
		OP_BRANCH_HALF_CARRY_CLEAR = 5'h08,
		OP_BRANCH_TRANSFER_FLAG_SET = 5'h09,
		OP_BRANCH_TRANSFER_FLAG_CLEAR = 5'h0A,
		OP_BRANCH_IF_IRQ_ENABLED = 5'h0B,
		OP_BRANCH_IF_IRQ_DISABLED = 5'h0C,
		OP_BRANCH_STATUS_BIT_SET = 5'h0D,
		OP_BRANCH_STATUS_BIT_CLEAR = 5'h0E,
		OP_SET_IO_BIT = 5'h0F,
		OP_CLEAR_IO_BIT = 5'h10,
		OP_SHIFT_LEFT_LOGICAL = 5'h11,
		OP_SHIFT_RIGHT_LOGICAL = 5'h12,
		OP_SHIFT_RIGHT_ARITH = 5'h13,
		OP_ROTATE_LEFT_THRU_CARRY = 5'h14,
		OP_ROTATE_RIGHT_THRU_CARRY = 5'h15,
		OP_STORE_REG_BIT_TO_TRANSFER = 5'h16,
		OP_LOAD_REG_BIT_FROM_TRANSFER = 5'h17,
		OP_GLOBAL_IRQ_ENABLE = 5'h18,
		OP_GLOBAL_IRQ_DISABLE = 5'h19,
		OP_FLAG_SET = 5'h1A,
		OP_FLAG_CLEAR = 5'h1B
	} bfx_op_e;

	typedef enum logic [2:0] {
		BFX_IDLE = 3'b001,
		BFX_BR2 = 3'b010,
		BFX_IO2 = 3'b100
	} bfx_state_e;

endpackage

// *** design/bfx_shifter.sv ***
/*
 * Eight-bit shift and rotate datapath with carry out.
 * Assumes flags carry the current carry flag for the rotates.
 */
module bfx_shifter import bfx_pkg::*; (
	bfx_exec_if.shift bus
);
	always_comb begin
		bus.shift_res = bus.value;
		bus.shift_c = bus.flags[FLAG_C];
		bus.is_shift = 1'b1;
		case (bus.op)
			OP_SHIFT_LEFT_LOGICAL: begin
				bus.shift_res = {bus.value[6:0], 1'b0};
				bus.shift_c = bus.value[7];
			end
			OP_SHIFT_RIGHT_LOGICAL: begin
				bus.shift_res = {1'b0, bus.value[7:1]};
				bus.shift_c = bus.value[0];
			end
			OP_SHIFT_RIGHT_ARITH: begin
				// sign bit kept so signed halving stays signed
				bus.shift_res = {bus.value[7], bus.value[7:1]};
				bus.shift_c = bus.value[0];
			end
			OP_ROTATE_LEFT_THRU_CARRY: begin
				bus.shift_res = {bus.value[6:0], bus.flags[FLAG_C]};
				bus.shift_c = bus.value[7];
			end
			OP_ROTATE_RIGHT_THRU_CARRY: begin
				bus.shift_res = {bus.flags[FLAG_C], bus.value[7:1]};
				bus.shift_c = bus.value[0];
			end
			default: begin
				bus.is_shift = 1'b0;
			end
		endcase
	end
endmodule // bfx_shifter

// *** testbench/tb.sv ***
/*
 * Self-checking bench for the branch, bit and flag execution unit.
 * Assumes the bench plays decoder, I/O space and software on one clock.
 */
module tb import bfx_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic mclk, rst_b, op_valid, op_ready, op_done, reg_wr, pc_load;
	logic io_rd, io_wr, sw_wr, sw_rd, t;
	bfx_op_e op_code, c;
	logic [7:0] op_value, reg_wdata, io_wdata, io_rdata, sw_wdata, sw_rdata;
	logic [7:0] status_flags, fl, v, rd, rdv_v;
	logic [2:0] op_bit, b;
	logic [4:0] op_io_addr, io_addr, ioa_v;
	logic [6:0] op_offset, off_v;
	logic [15:0] op_pc, pc_target, exp_pc, pc_v;
	logic [1:0] sw_addr;
	logic [8:0] r;
	int bad_count, total_checks, seed, cyc;

	bfx_exec i_bfx_exec (.mclk(mclk), .rst_b(rst_b), .op_valid(op_valid),
		.op_code(op_code), .op_value(op_value), .op_bit(op_bit),
		.op_io_addr(op_io_addr), .op_offset(op_offset), .op_pc(op_pc),
		.op_ready(op_ready), .op_done(op_done), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .pc_load(pc_load), .pc_target(pc_target),
		.io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.status_flags(status_flags));

	function automatic logic taken(bfx_op_e o, logic [7:0] f, logic [2:0] s);
		case (o)
			OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_UNSIGNED_GE: return !f[FLAG_C];
			OP_BRANCH_UNSIGNED_LOWER: return f[FLAG_C];
			OP_BRANCH_IF_NEGATIVE: return f[FLAG_N];
			OP_BRANCH_IF_NONNEGATIVE: return !f[FLAG_N];
			OP_BRANCH_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
			OP_BRANCH_SIGNED_LESS: return f[FLAG_N] ^ f[FLAG_V];
			OP_BRANCH_HALF_CARRY_SET: return f[FLAG_H];
			OP_BRANCH_HALF_CARRY_CLEAR: return !f[FLAG_H];
			OP_BRANCH_TRANSFER_FLAG_SET: return f[FLAG_T];
			OP_BRANCH_TRANSFER_FLAG_CLEAR: return !f[FLAG_T];
			OP_BRANCH_IF_IRQ_ENABLED: return f[FLAG_I];
			OP_BRANCH_IF_IRQ_DISABLED: return !f[FLAG_I];
			OP_BRANCH_STATUS_BIT_SET: return f[s];
			default: return !f[s];
		endcase
	endfunction

	// carry out on top, result below
	function automatic logic [8:0] shift_exp(bfx_op_e o, logic [7:0] d,
		logic ci);
		case (o)
			OP_SHIFT_LEFT_LOGICAL: return {d[7], d[6:0], 1'b0};
			OP_SHIFT_RIGHT_LOGICAL: return {d[0], 1'b0, d[7:1]};
			OP_SHIFT_RIGHT_ARITH: return {d[0], d[7], d[7:1]};
			OP_ROTATE_LEFT_THRU_CARRY: return {d[7], d[6:0], ci};
			default: return {d[0], ci, d[7:1]};
		endcase
	endfunction

	task automatic close_out;
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic step;
		@(posedge mclk);
		#1;
	endtask

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic sw_write(logic [1:0] a, logic [7:0] d);
		@(posedge mclk);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge mclk);
		sw_wr <= 1'b0;
		#1;
	endtask

	task automatic sw_read(logic [1:0] a, output logic [7:0] d);
		@(posedge mclk);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge mclk);
		sw_rd <= 1'b0;
		#1;
		d = sw_rdata;
	endtask

	task automatic set_flags(logic [7:0] d);
		sw_write(REG_STATUS_ADDR, d);
		fl = d;
	endtask

	// returns sampling the cycle after the accept edge
	task automatic issue(bfx_op_e o, logic [7:0] d, logic [2:0] s);
		@(posedge mclk);
		op_valid <= 1'b1;
		op_code <= o;
		op_value <= d;
		op_bit <= s;
		op_offset <= off_v;
		op_pc <= pc_v;
		op_io_addr <= ioa_v;
		io_rdata <= rdv_v;
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
	endtask

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			close_out;
		end
	end

	initial begin
		seed = 63744;
		{rst_b, op_valid, sw_wr, sw_rd, op_value, op_bit, sw_addr} = '0;
		{op_io_addr, op_offset, op_pc, io_rdata, sw_wdata} = '0;
		{off_v, pc_v, ioa_v, rdv_v} = '0;
		op_code = OP_FLAG_SET;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		#1;
		chk("status reset", 16'(STATUS_RST), 16'(status_flags));
		chk("op_ready reset", 16'h0001, 16'(op_ready));
		sw_read(2'h3, rd);
		chk("unmapped read", 16'h0000, 16'(rd));
		sw_read(REG_STATE_ADDR, rd);
		chk("state idle", 16'h0001, 16'(rd));
		step;
		chk("rdata idle", 16'h0000, 16'(sw_rdata));
		sw_write(2'h3, 8'hFF);
		chk("unmapped write", 16'h0000, 16'(status_flags));
		set_flags(8'($random(seed)));
		sw_read(REG_STATUS_ADDR, rd);
		chk("status read", 16'(fl), 16'(rd));
		for (int i = 0; i < 75; i++) begin
			c = bfx_op_e'(5'(i % 15));
			set_flags(i < 15 ? 8'h55 : i < 30 ? 8'hAA : i < 45 ? 8'h00 :
				8'($random(seed)));
			b = 3'($random(seed));
			off_v = i < 15 ? 7'h3F : i < 30 ? 7'h40 : 7'($random(seed));
			pc_v = (i % 7 == 0) ? 16'hFFFF : 16'($random(seed));
			t = taken(c, fl, b);
			exp_pc = pc_v + {{9{off_v[6]}}, off_v} + 16'h0001;
			issue(c, 8'h00, b);
			chk("pc_target", exp_pc, pc_target);
			chk("op_done", 16'(!t), 16'(op_done));
			chk("op_ready", 16'(!t), 16'(op_ready));
			chk("pc_load early", 16'h0000, 16'(pc_load));
			step;
			chk("pc_load", 16'(t), 16'(pc_load));
			chk("op_done late", 16'(t), 16'(op_done));
			chk("flags", 16'(fl), 16'(status_flags));
		end
		for (int i = 0; i < 50; i++) begin
			c = bfx_op_e'(5'h11 + 5'(i % 5));
			set_flags(8'($random(seed)));
			v = i < 5 ? 8'h80 : i < 10 ? 8'h01 : 8'($random(seed));
			r = shift_exp(c, v, fl[FLAG_C]);
			issue(c, v, 3'h0);
			chk("reg_wr", 16'h0001, 16'(reg_wr));
			chk("reg_wdata", 16'(r[7:0]), 16'(reg_wdata));
			chk("op_done", 16'h0001, 16'(op_done));
			fl[FLAG_C] = r[8];
			fl[FLAG_Z] = (r[7:0] == 8'h00);
			fl[FLAG_N] = r[7];
			fl[FLAG_V] = r[7] ^ r[8];
			chk("flags", 16'(fl), 16'(status_flags));
		end
		sw_read(REG_RESULT_ADDR, rd);
		chk("result", 16'(r[7:0]), 16'(rd));
		for (int i = 0; i < 32; i++) begin
			v = 8'($random(seed));
			b = 3'($random(seed));
			issue(OP_STORE_REG_BIT_TO_TRANSFER, v, b);
			fl[FLAG_T] = v[b];
			chk("flags", 16'(fl), 16'(status_flags));
			v = 8'($random(seed));
			b = 3'($random(seed));
			rd = v;
			rd[b] = fl[FLAG_T];
			issue(OP_LOAD_REG_BIT_FROM_TRANSFER, v, b);
			chk("reg_wr", 16'h0001, 16'(reg_wr));
			chk("reg_wdata", 16'(rd), 16'(reg_wdata));
			chk("flags", 16'(fl), 16'(status_flags));
		end
		set_flags(8'h5A);
		for (int i = 0; i < 20; i++) begin
			b = 3'(i);
			if (i >= 16)
				c = i[0] ? OP_GLOBAL_IRQ_DISABLE : OP_GLOBAL_IRQ_ENABLE;
			else
				c = i[3] ? OP_FLAG_CLEAR : OP_FLAG_SET;
			issue(c, 8'h00, b);
			if (i >= 16)
				fl[FLAG_I] = !i[0];
			else
				fl[b] = !i[3];
			chk("flags", 16'(fl), 16'(status_flags));
			chk("op_done", 16'h0001, 16'(op_done));
			chk("reg_wr", 16'h0000, 16'(reg_wr));
		end
		for (int i = 0; i < 20; i++) begin
			ioa_v = 5'($random(seed));
			rdv_v = i < 2 ? 8'hFF : i < 4 ? 8'h00 : 8'($random(seed));
			b = 3'($random(seed));
			c = i[0] ? OP_CLEAR_IO_BIT : OP_SET_IO_BIT;
			rd = rdv_v;
			rd[b] = !i[0];
			issue(c, 8'h00, b);
			chk("io_rd", 16'h0001, 16'(io_rd));
			chk("io_addr", 16'(ioa_v), 16'(io_addr));
			chk("op_done early", 16'h0000, 16'(op_done));
			chk("io_wr early", 16'h0000, 16'(io_wr));
			step;
			chk("io_wr", 16'h0001, 16'(io_wr));
			chk("io_wdata", 16'(rd), 16'(io_wdata));
			chk("op_done", 16'h0001, 16'(op_done));
			chk("flags", 16'(fl), 16'(status_flags));
		end
		// a request held while busy waits, then ops run back to back
		set_flags(8'h00);
		@(posedge mclk);
		op_valid <= 1'b1;
		op_code <= OP_SET_IO_BIT;
		op_bit <= 3'h2;
		io_rdata <= 8'h00;
		@(posedge mclk);
		op_code <= OP_GLOBAL_IRQ_ENABLE;
		#1;
		chk("op_ready busy", 16'h0000, 16'(op_ready));
		step;
		chk("io_wdata", 16'h0004, 16'(io_wdata));
		chk("op_done io", 16'h0001, 16'(op_done));
		chk("flags wait", 16'h0000, 16'(status_flags));
		@(posedge mclk);
		op_code <= OP_FLAG_SET;
		op_bit <= FLAG_C;
		sw_wr <= 1'b1;
		sw_addr <= REG_STATUS_ADDR;
		sw_wdata <= 8'hF0;
		#1;
		chk("irq enable", 16'h0080, 16'(status_flags));
		chk("op_done", 16'h0001, 16'(op_done));
		@(posedge mclk);
		op_valid <= 1'b0;
		sw_wr <= 1'b0;
		#1;
		chk("flag set", 16'h00F1, 16'(status_flags));
		chk("op_done", 16'h0001, 16'(op_done));
		// mid-run reset, then a request on the first edge after release
		@(posedge mclk);
		rst_b <= 1'b0;
		#1;
		chk("status reset", 16'(STATUS_RST), 16'(status_flags));
		chk("op_ready reset", 16'h0001, 16'(op_ready));
		@(posedge mclk);
		rst_b <= 1'b1;
		op_valid <= 1'b1;
		op_code <= OP_FLAG_SET;
		op_bit <= FLAG_Z;
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
		chk("first op", 16'h0002, 16'(status_flags));
		close_out;
	end
endmodule // tb
